/* tpc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_timer #(
    parameter int INSN_CLKS = tpc_pkg::INSN_CLKS,
    parameter int ADDR_W    = tpc_pkg::ADDR_W
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Write address and data
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    // Write response
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // Read address and data
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Pins
    input  wire logic              ext_count_clock,
    input  wire logic              lp_osc_clock,
    input  wire logic              gate_input_n,
    // System oscillator mode, same clock domain
    input  wire logic              internal_oscillator_no_clkout,
    // Status outputs
    output logic                   lp_osc_active,
    output logic                   irq
);
    localparam int INSN_W = (INSN_CLKS > 1) ? $clog2(INSN_CLKS) : 1;
    localparam logic [INSN_W-1:0] INSN_LAST = INSN_W'(INSN_CLKS - 1);

    tpc_psc_if psc ();

    logic [tpc_pkg::CTRL_W-1:0]  ctrl_reg;
    logic [tpc_pkg::COUNT_W-1:0] count_reg;
    logic [tpc_pkg::IRQ_W-1:0]   status_reg;
    logic [tpc_pkg::IRQ_W-1:0]   enable_reg;
    logic [ADDR_W-1:0]           waddr_reg;
    logic [31:0]                 wdata_reg;
    logic                        wstrb0_reg;
    logic [INSN_W-1:0]           insn_cnt_reg;
    logic                        ext_meta_reg;
    logic                        ext_sync_reg;
    logic                        lp_meta_reg;
    logic                        lp_sync_reg;
    logic                        gate_meta_reg;
    logic                        gate_sync_reg;
    logic                        src_prev_reg;
    logic                        armed_reg;
    logic                        pend_reg;
    logic                        wr_fire;
    logic                        wr_count;
    logic                        wr_hit;
    logic                        insn_tick;
    logic                        src;
    logic                        ext_rise;
    logic                        ext_event;
    logic                        count_en;
    logic                        count_inc;
    logic                        wrap;
    logic                        timer_on;
    logic                        clock_source_select;
    logic                        ext_sync_disable;
    logic                        gate_enable;
    logic [31:0]                 rd_data;
    logic                        rd_hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Control fields
    assign timer_on            = ctrl_reg[tpc_pkg::CTRL_ON];
    assign clock_source_select = ctrl_reg[tpc_pkg::CTRL_CS];
    assign ext_sync_disable    = ctrl_reg[tpc_pkg::CTRL_SYNC_DIS];
    assign gate_enable         = ctrl_reg[tpc_pkg::CTRL_GE];

    // Write channel: both halves held, then one write per response
    assign wr_fire  = !s_awready && !s_wready && !s_bvalid;
    assign wr_count = wr_fire && wstrb0_reg &&
                      (waddr_reg == tpc_pkg::ADDR_COUNT_LOW ||
                       waddr_reg == tpc_pkg::ADDR_COUNT_HIGH);
    assign wr_hit   = waddr_reg == tpc_pkg::ADDR_COUNT_LOW  ||
                      waddr_reg == tpc_pkg::ADDR_COUNT_HIGH ||
                      waddr_reg == tpc_pkg::ADDR_CONTROL    ||
                      waddr_reg == tpc_pkg::ADDR_IRQ_ENABLE ||
                      waddr_reg == tpc_pkg::ADDR_IRQ_CLEAR;

    // Write handshake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_awready  <= 1'b1;
            s_wready   <= 1'b1;
            s_bvalid   <= 1'b0;
            s_bresp    <= tpc_pkg::RESP_OKAY;
            waddr_reg  <= '0;
            wdata_reg  <= '0;
            wstrb0_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (s_awvalid && s_awready)
            begin
                s_awready <= 1'b0;
                waddr_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                s_wready   <= 1'b0;
                wdata_reg  <= s_wdata;
                wstrb0_reg <= s_wstrb[0];
            end
            if (wr_fire)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_hit ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // Control register; bit 7 has no storage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= tpc_pkg::CTRL_RESET;
        else if (ce && wr_fire && wstrb0_reg && waddr_reg == tpc_pkg::ADDR_CONTROL)
            ctrl_reg <= wdata_reg[tpc_pkg::CTRL_W-1:0];
    end

    // Interrupt enable register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_reg <= '0;
        else if (ce && wr_fire && wstrb0_reg && waddr_reg == tpc_pkg::ADDR_IRQ_ENABLE)
            enable_reg <= wdata_reg[tpc_pkg::IRQ_W-1:0];
    end

    // Sticky status: overflow set wins over a same-cycle clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            status_reg <= '0;
        else if (ce)
        begin
            if (wr_fire && wstrb0_reg && waddr_reg == tpc_pkg::ADDR_IRQ_CLEAR)
                status_reg <= status_reg & ~wdata_reg[tpc_pkg::IRQ_W-1:0];
            if (wrap)
                status_reg[tpc_pkg::IRQ_OVERFLOW] <= 1'b1;
        end
    end

    // Interrupt level and oscillator status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq           <= 1'b0;
            lp_osc_active <= 1'b0;
        end
        else if (ce)
        begin
            irq           <= |(status_reg & enable_reg);
            lp_osc_active <= ctrl_reg[tpc_pkg::CTRL_LP_EN] &&
                             internal_oscillator_no_clkout;
        end
    end

    // Read decode; the prescale counter has no address
    always_comb
    begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case (s_araddr)
            tpc_pkg::ADDR_COUNT_LOW:  rd_data[7:0] = count_reg[7:0];
            tpc_pkg::ADDR_COUNT_HIGH: rd_data[7:0] = count_reg[15:8];
            tpc_pkg::ADDR_CONTROL:    rd_data[tpc_pkg::CTRL_W-1:0] = ctrl_reg;
            tpc_pkg::ADDR_IRQ_STATUS: rd_data[tpc_pkg::IRQ_W-1:0] = status_reg;
            tpc_pkg::ADDR_IRQ_ENABLE: rd_data[tpc_pkg::IRQ_W-1:0] = enable_reg;
            tpc_pkg::ADDR_IRQ_CLEAR:  rd_data = '0;
            default:                  rd_hit = 1'b0;
        endcase
    end

    // Read handshake, data one cycle after the address is taken
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= tpc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_arvalid && s_arready)
            begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_data;
                s_rresp   <= rd_hit ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_meta_reg  <= 1'b0;
            ext_sync_reg  <= 1'b0;
            lp_meta_reg   <= 1'b0;
            lp_sync_reg   <= 1'b0;
            gate_meta_reg <= 1'b1;
            gate_sync_reg <= 1'b1;
        end
        else if (ce)
        begin
            ext_meta_reg  <= ext_count_clock;
            ext_sync_reg  <= ext_meta_reg;
            lp_meta_reg   <= lp_osc_clock;
            lp_sync_reg   <= lp_meta_reg;
            gate_meta_reg <= gate_input_n;
            gate_sync_reg <= gate_meta_reg;
        end
    end

    // Instruction cycle divider
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            insn_cnt_reg <= '0;
        else if (ce)
            insn_cnt_reg <= insn_tick ? '0 : insn_cnt_reg + 1'b1;
    end
    assign insn_tick = insn_cnt_reg == INSN_LAST;

    // External source: pin or low-power oscillator
    assign src      = lp_osc_active ? lp_sync_reg : ext_sync_reg;
    assign ext_rise = src && !src_prev_reg && armed_reg;

    // Edge history and arming on a low level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            src_prev_reg <= 1'b0;
            armed_reg    <= 1'b0;
            pend_reg     <= 1'b0;
        end
        else if (ce)
        begin
            src_prev_reg <= src;
            armed_reg    <= timer_on && clock_source_select &&
                            (armed_reg || !src);
            pend_reg     <= ext_rise || (pend_reg && !insn_tick);
        end
    end

    // Synchronised edges wait for an instruction boundary
    assign ext_event = ext_sync_disable ? ext_rise : (pend_reg && insn_tick);
    assign count_en  = timer_on && !(gate_enable && gate_sync_reg);

    // Prescaler connection
    assign psc.tick  = count_en && (clock_source_select ? ext_event : insn_tick);
    assign psc.clear = wr_count;
    assign psc.sel   = ctrl_reg[tpc_pkg::CTRL_PS_MSB:tpc_pkg::CTRL_PS_LSB];

    tpc_prescaler #(
        .W   (tpc_pkg::PSC_W)
    ) u_psc (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .p   (psc.psc)
    );

    assign count_inc = psc.done && count_en && !wr_count;
    assign wrap      = count_inc && count_reg == tpc_pkg::COUNT_MAX;

    // Count register; a byte write wins over an increment
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_reg <= tpc_pkg::COUNT_ZERO;
        else if (ce)
        begin
            if (wr_count && waddr_reg == tpc_pkg::ADDR_COUNT_LOW)
                count_reg[7:0] <= wdata_reg[7:0];
            else if (wr_count)
                count_reg[15:8] <= wdata_reg[7:0];
            else if (count_inc)
                count_reg <= count_reg + 1'b1;
        end
    end

    sequence s_wrap_hit;
        ce && count_inc && count_reg == tpc_pkg::COUNT_MAX;
    endsequence

    chk_wrap_flag: assert property (s_wrap_hit |=> (count_reg == '0 && status_reg[0]))
        else $error("count did not wrap with overflow flag");
    chk_count_step: assert property ((ce && count_inc && count_reg != tpc_pkg::COUNT_MAX) |=>
        count_reg == $past(count_reg) + 16'h0001)
        else $error("count did not advance by one");
    chk_off_holds: assert property ((ce && !timer_on && !wr_count) |=> $stable(count_reg))
        else $error("count moved while timer off");
    chk_gate_blocks: assert property ((timer_on && gate_enable && gate_sync_reg) |->
        (!psc.tick && !count_inc))
        else $error("count advanced with gate pin high");
    chk_insn_feed: assert property ((ce && psc.tick && !clock_source_select) |=>
        (!psc.tick || INSN_CLKS == 1))
        else $error("internal mode ticks closer than one instruction");
    chk_first_rise: assert property ((ce && timer_on && clock_source_select && !armed_reg)
        |-> !psc.tick)
        else $error("rising edge counted before a low level");
    chk_sync_align: assert property ((clock_source_select && !ext_sync_disable && psc.tick)
        |-> insn_tick)
        else $error("synchronised edge not on instruction boundary");
    chk_ctrl_bit7: assert property ((ce && s_arvalid && s_arready && s_araddr ==
        tpc_pkg::ADDR_CONTROL) |=> (s_rvalid && !s_rdata[7]))
        else $error("control bit 7 read as one");
endmodule // tpc_timer
`default_nettype wire

/* tpc_pkg.sv */
package tpc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_COUNT_LOW   = 6'h0e;
    localparam logic [5:0] IDX_COUNT_HIGH  = 6'h0f;
    localparam logic [5:0] IDX_CONTROL     = 6'h10;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h20;
    localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h21;
    localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h22;

    // Byte addresses on the register bus
    localparam logic [7:0] ADDR_COUNT_LOW  = {IDX_COUNT_LOW, 2'h0};
    localparam logic [7:0] ADDR_COUNT_HIGH = {IDX_COUNT_HIGH, 2'h0};
    localparam logic [7:0] ADDR_CONTROL    = {IDX_CONTROL, 2'h0};
    localparam logic [7:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'h0};
    localparam logic [7:0] ADDR_IRQ_CLEAR  = {IDX_IRQ_CLEAR, 2'h0};
    localparam int         ADDR_W          = 8;

    // Control register layout
    localparam int         CTRL_W          = 7;
    localparam logic [6:0] CTRL_RESET      = 7'h00;
    localparam int         CTRL_ON         = 0;
    localparam int         CTRL_CS         = 1;
    localparam int         CTRL_SYNC_DIS   = 2;
    localparam int         CTRL_LP_EN      = 3;
    localparam int         CTRL_PS_LSB     = 4;
    localparam int         CTRL_PS_MSB     = 5;
    localparam int         CTRL_GE         = 6;

    // Prescaler terminal values for 1, 2, 4 and 8
    localparam int         PSC_W           = 3;
    localparam logic [2:0] PSC_LAST_DIV1   = 3'h0;
    localparam logic [2:0] PSC_LAST_DIV2   = 3'h1;
    localparam logic [2:0] PSC_LAST_DIV4   = 3'h3;
    localparam logic [2:0] PSC_LAST_DIV8   = 3'h7;
    localparam logic [1:0] PS_DIV1         = 2'h0;
    localparam logic [1:0] PS_DIV2         = 2'h1;
    localparam logic [1:0] PS_DIV4         = 2'h2;
    localparam logic [1:0] PS_DIV8         = 2'h3;

    // Count, timing and interrupt
    localparam int         COUNT_W         = 16;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam int         INSN_CLKS       = 4;
    localparam int         IRQ_W           = 1;
    localparam int         IRQ_OVERFLOW    = 0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage

/* tpc_psc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tpc_psc_if;
    logic       tick;
    logic       clear;
    logic [1:0] sel;
    logic       done;
    modport ctrl (output tick, output clear, output sel, input done);
    modport psc (input tick, input clear, input sel, output done);
endinterface // tpc_psc_if
`default_nettype wire

/* tpc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_prescaler #(
    parameter int W = tpc_pkg::PSC_W
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Timer side
    tpc_psc_if.psc    p
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] last;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Terminal count for the selected ratio
    always_comb
    begin
        unique case (p.sel)
            tpc_pkg::PS_DIV1: last = W'(tpc_pkg::PSC_LAST_DIV1);
            tpc_pkg::PS_DIV2: last = W'(tpc_pkg::PSC_LAST_DIV2);
            tpc_pkg::PS_DIV4: last = W'(tpc_pkg::PSC_LAST_DIV4);
            tpc_pkg::PS_DIV8: last = W'(tpc_pkg::PSC_LAST_DIV8);
        endcase
    end

    // Divide counter, cleared by count writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= '0;
            p.done  <= 1'b0;
        end
        else if (ce)
        begin
            p.done <= 1'b0;
            if (p.clear)
                cnt_reg <= '0;
            else if (p.tick && cnt_reg >= last)
            begin
                cnt_reg <= '0;
                p.done  <= 1'b1;
            end
            else if (p.tick)
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    chk_div_ratio: assert property ((ce && p.tick && !p.clear && cnt_reg == last) |=> p.done)
        else $error("prescaler missed its terminal count");
    chk_psc_clear: assert property ((ce && p.clear) |=> (cnt_reg == '0 && !p.done))
        else $error("prescaler not cleared by count write");
endmodule // tpc_prescaler
`default_nettype wire

/* tpc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_partner (
    // Clock
    input  wire logic clk,
    // Pins toward the timer
    output logic      ext_count_clock,
    output logic      lp_osc_clock,
    output logic      gate_input_n
);
    // Half period in clocks, longer than the pin synchroniser
    localparam int HALF = 6;

    // Idle levels: clocks parked low, gate closed
    initial
    begin
        ext_count_clock = 1'b0;
        lp_osc_clock    = 1'b0;
        gate_input_n    = 1'b1;
    end

    // Park both clock pins at one level and set the gate pin
    task automatic park(input logic lvl, input logic gate_n);
    begin
        @(posedge clk);
        ext_count_clock <= lvl;
        lp_osc_clock    <= lvl;
        gate_input_n    <= gate_n;
    end
    endtask

    // Send n low-then-high periods on the chosen pin; clock stands still afterwards
    task automatic pulses(input logic [7:0] n, input logic use_lp);
        int i;
    begin
        for (i = 0; i < n; i++)
        begin
            repeat (HALF) @(posedge clk);
            ext_count_clock <= use_lp ? ext_count_clock : 1'b0;
            lp_osc_clock    <= use_lp ? 1'b0 : lp_osc_clock;
            repeat (HALF) @(posedge clk);
            ext_count_clock <= use_lp ? ext_count_clock : 1'b1;
            lp_osc_clock    <= use_lp ? 1'b1 : lp_osc_clock;
        end
    end
    endtask
endmodule // tpc_partner
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Short instruction cycle keeps the run brief
    localparam int INSN = 2;
    typedef struct packed {
        logic [7:0] ctrl;
        logic       hi;
        logic       gate_n;
        logic       osc;
        logic       lp;
        logic [7:0] n;
        logic [7:0] cnt;
        logic       act;
    } tpc_tb_row_t;
    // Control, start level, gate, osc mode, lp source, pulses -> count, lp active
    localparam tpc_tb_row_t ROWS [12] = '{
        '{8'h07, 1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 8'h08, 1'b0},
        '{8'h17, 1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 8'h04, 1'b0},
        '{8'h27, 1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 8'h02, 1'b0},
        '{8'h37, 1'b0, 1'b1, 1'b0, 1'b0, 8'h10, 8'h02, 1'b0},
        '{8'h33, 1'b0, 1'b1, 1'b0, 1'b0, 8'h10, 8'h02, 1'b0},
        '{8'h47, 1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 8'h00, 1'b0},
        '{8'h47, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08, 8'h08, 1'b0},
        '{8'h46, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08, 8'h00, 1'b0},
        '{8'h06, 1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 8'h00, 1'b0},
        '{8'h07, 1'b1, 1'b1, 1'b0, 1'b0, 8'h05, 8'h05, 1'b0},
        '{8'h0f, 1'b0, 1'b1, 1'b1, 1'b1, 8'h04, 8'h04, 1'b1},
        '{8'h0f, 1'b0, 1'b1, 1'b0, 1'b0, 8'h04, 8'h04, 1'b0}
    };
    logic        clk, rst, ce, osc_mode, s_awvalid, s_awready, s_wvalid, s_wready;
    logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    logic        ext_count_clock, lp_osc_clock, gate_input_n, lp_osc_active, irq;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, last_resp;
    int          fail_count, checked, cycles;

    tpc_timer #(.INSN_CLKS(INSN), .ADDR_W(tpc_pkg::ADDR_W)) u_tpc_timer (
        .clk(clk), .rst(rst), .ce(ce),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .ext_count_clock(ext_count_clock), .lp_osc_clock(lp_osc_clock),
        .gate_input_n(gate_input_n), .internal_oscillator_no_clkout(osc_mode),
        .lp_osc_active(lp_osc_active), .irq(irq)
    );
    tpc_partner u_tpc_partner (
        .clk(clk), .ext_count_clock(ext_count_clock),
        .lp_osc_clock(lp_osc_clock), .gate_input_n(gate_input_n)
    );

    // Clock of 40 ns
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Verdict and end of run
    task automatic close_out;
    begin
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            close_out();
        end
    end

    // Value compare
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    begin
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    // Range compare for counts with a latency margin
    task automatic chk_range(input string name, input int lo, input int hi,
                             input logic [31:0] seen);
        logic ok;
    begin
        ok = (seen >= lo) && (seen <= hi);
        checked++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("BAD %s expected %0d..%0d seen %h", name, lo, hi, seen);
        end
    end
    endtask

    // Bus write; each valid drops at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
    begin
        @(posedge clk);
        s_awaddr  <= a;
        s_wdata   <= {24'h000000, v};
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid)
            begin
                last_resp = s_bresp;
                break;
            end
        end
        s_bready <= 1'b0;
    end
    endtask

    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
    begin
        @(posedge clk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid)
            begin
                v = s_rdata;
                last_resp = s_rresp;
                break;
            end
        end
        s_rready <= 1'b0;
    end
    endtask

    // Main sequence
    initial
    begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, osc_mode} = 6'h00;
        s_awaddr = 8'h00;
        s_araddr = 8'h00;
        s_wdata  = 32'h00000000;
        s_wstrb  = 4'h1;
        ce       = 1'b1;
        rst      = 1'b1;
        {fail_count, checked, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(tpc_pkg::ADDR_CONTROL, d);
        chk("control reset", 32'h00, d);
        rd(tpc_pkg::ADDR_COUNT_LOW, d);
        chk("count reset", 32'h00, d);
        wr(tpc_pkg::ADDR_CONTROL, 8'hff);
        chk("mapped bresp", {30'h0, tpc_pkg::RESP_OKAY}, {30'h0, last_resp});
        rd(tpc_pkg::ADDR_CONTROL, d);
        chk("control top bit", 32'h7f, d);
        chk("mapped rresp", {30'h0, tpc_pkg::RESP_OKAY}, {30'h0, last_resp});
        // Table of count sources, ratios and gating
        foreach (ROWS[i])
        begin
            wr(tpc_pkg::ADDR_CONTROL, 8'h00);
            osc_mode <= ROWS[i].osc;
            u_tpc_partner.park(ROWS[i].hi, ROWS[i].gate_n);
            wr(tpc_pkg::ADDR_COUNT_LOW, 8'h00);
            wr(tpc_pkg::ADDR_COUNT_HIGH, 8'h00);
            wr(tpc_pkg::ADDR_CONTROL, ROWS[i].ctrl);
            u_tpc_partner.pulses(ROWS[i].n, ROWS[i].lp);
            repeat (12) @(posedge clk);
            chk("lp_osc_active", {31'h0, ROWS[i].act}, {31'h0, lp_osc_active});
            rd(tpc_pkg::ADDR_COUNT_LOW, d);
            chk("count", {24'h0, ROWS[i].cnt}, d);
            rd(tpc_pkg::ADDR_CONTROL, d);
            chk("control", {24'h0, ROWS[i].ctrl}, d);
        end
        // Count byte write in mid-division restarts the divide by 8
        wr(tpc_pkg::ADDR_CONTROL, 8'h00);
        u_tpc_partner.park(1'b0, 1'b1);
        wr(tpc_pkg::ADDR_CONTROL, 8'h37);
        u_tpc_partner.pulses(8'h05, 1'b0);
        wr(tpc_pkg::ADDR_COUNT_LOW, 8'h00);
        u_tpc_partner.pulses(8'h03, 1'b0);
        repeat (12) @(posedge clk);
        rd(tpc_pkg::ADDR_COUNT_LOW, d);
        chk("count after clear", 32'h00, d);
        u_tpc_partner.pulses(8'h05, 1'b0);
        repeat (12) @(posedge clk);
        rd(tpc_pkg::ADDR_COUNT_LOW, d);
        chk("count after eight", 32'h01, d);
        // Rollover, interrupt raise, mask and clear
        wr(tpc_pkg::ADDR_CONTROL, 8'h00);
        u_tpc_partner.park(1'b0, 1'b1);
        wr(tpc_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(tpc_pkg::ADDR_COUNT_LOW, 8'hff);
        wr(tpc_pkg::ADDR_IRQ_ENABLE, 8'h01);
        wr(tpc_pkg::ADDR_CONTROL, 8'h07);
        u_tpc_partner.pulses(8'h01, 1'b0);
        repeat (12) @(posedge clk);
        rd(tpc_pkg::ADDR_COUNT_HIGH, d);
        chk("count high wrap", 32'h00, d);
        rd(tpc_pkg::ADDR_IRQ_STATUS, d);
        chk("overflow flag", 32'h01, d);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(tpc_pkg::ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(tpc_pkg::ADDR_IRQ_ENABLE, 8'h01);
        wr(tpc_pkg::ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(tpc_pkg::ADDR_IRQ_STATUS, d);
        chk("flag cleared", 32'h00, d);
        // Internal clock, one prescaler step per instruction cycle, divide by 8
        wr(tpc_pkg::ADDR_CONTROL, 8'h00);
        wr(tpc_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(tpc_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(tpc_pkg::ADDR_CONTROL, 8'h31);
        repeat (80) @(posedge clk);
        // Clock enable low freezes the count, so the range below still holds
        ce <= 1'b0;
        repeat (80) @(posedge clk);
        ce <= 1'b1;
        wr(tpc_pkg::ADDR_CONTROL, 8'h00);
        rd(tpc_pkg::ADDR_COUNT_LOW, d);
        chk_range("internal count", 80 / (INSN * 8) - 1, 80 / (INSN * 8) + 1, d);
        // No address reaches the prescale counter
        wr(8'h00, 8'h55);
        chk("unmapped bresp", {30'h0, tpc_pkg::RESP_SLVERR}, {30'h0, last_resp});
        rd(8'h00, d);
        chk("unmapped rdata", 32'h00, d);
        chk("unmapped rresp", {30'h0, tpc_pkg::RESP_SLVERR}, {30'h0, last_resp});
        // Reset in mid-run with the timer counting
        wr(tpc_pkg::ADDR_CONTROL, 8'h31);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("readies", 32'h7, {29'h0, s_awready, s_wready, s_arready});
        rd(tpc_pkg::ADDR_CONTROL, d);
        chk("control after reset", 32'h00, d);
        rd(tpc_pkg::ADDR_COUNT_LOW, d);
        chk("count after reset", 32'h00, d);
        close_out();
    end
endmodule // testbench
`default_nettype wire
